/* src/bfm_top.sv */
// breaker failure monitor: trigger selection, supervision fsm, lock latch, registers and interrupt
// assumes trip commands and current samples come from logic on clk_i; position pin is asynchronous
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "bfm_map.svh"
module bfm_top
	import bfm_pkg::*;
#(
	parameter int CW = 16,
	parameter int TW = 32,
	parameter int NX = 3
) (
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	input  wire logic [`BFM_AW-1:0] addr_i,
	input  wire logic [`BFM_DW-1:0] wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [`BFM_DW-1:0] rdata_o,
	input  wire logic              trip_ext_i,
	input  wire logic              trip_cur_i,
	input  wire logic              trip_other_i,
	input  wire logic [NX-1:0]     extra_trigger_i,
	input  wire logic [CW-1:0]     current_i,
	input  wire logic              pos_open_i,
	output logic                   backup_trip_o,
	output logic                   lock_o,
	output logic                   irq_o
);
	// ********************************************************
	// state
	// ********************************************************
	typedef struct packed {
		bfm_state_t    st;
		logic [1:0]    sch;
		logic [1:0]    tsel;
		logic [NX-1:0] xen;
		logic [CW-1:0] thr;
		logic [TW-1:0] supv;
		logic          lock;
		logic [2:0]    irq;
		logic [2:0]    mask;
		logic [`BFM_DW-1:0] rdata;
	} bfm_regs_t;

	bfm_regs_t r_q;
	bfm_regs_t r_d;

	logic          pos_open_s;
	logic          cur_below;
	logic          opened;
	logic          trig;
	logic          sel_trig;
	logic          start;
	logic          tmr_exp;
	logic [TW-1:0] tmr_cnt;
	logic          ack_wr;
	logic          irq_rd;

	// ********************************************************
	// pin synchroniser and timer
	// ********************************************************
	bfm_sync #(
		.W(1)
	) u_pos_sync (
		.clk_i (clk_i),
		.srst_i(srst_i),
		.d_i   (pos_open_i),
		.q_o   (pos_open_s)
	);

	bfm_timer #(
		.TW(TW)
	) u_timer (
		.clk_i     (clk_i),
		.srst_i    (srst_i),
		.load_i    (start),
		.stop_i    ((r_q.st == BFM_ST_RUN) && (opened || tmr_exp)),
		.load_val_i(r_q.supv),
		.cnt_o     (tmr_cnt),
		.exp_o     (tmr_exp)
	);

	// ********************************************************
	// trigger selection and opening detection
	// ********************************************************
	always_comb begin
		unique case (r_q.tsel)
			BFM_TS_ALL:     sel_trig = trip_ext_i || trip_cur_i || trip_other_i;
			BFM_TS_EXT:     sel_trig = trip_ext_i;
			BFM_TS_CURRENT: sel_trig = trip_cur_i;
			BFM_TS_NONE:    sel_trig = 1'b0;
		endcase
	end

	// extra inputs start the block even with selection set to none
	assign trig = sel_trig || |(extra_trigger_i & r_q.xen);

	assign cur_below = current_i < r_q.thr;

	always_comb begin
		unique case (r_q.sch)
			BFM_SCH_CURRENT:  opened = cur_below;
			BFM_SCH_POSITION: opened = pos_open_s;
			// one misleading indication must not stop supervision
			BFM_SCH_COMBINED: opened = cur_below && pos_open_s;
			default:          opened = cur_below && pos_open_s;
		endcase
	end

	assign start  = (r_q.st == BFM_ST_STANDBY) && trig;
	assign ack_wr = wr_i && (addr_i == `BFM_ACK_OFS) && wdata_i[0];
	assign irq_rd = rd_i && (addr_i == `BFM_IRQ_OFS);

	// ********************************************************
	// fsm and registers
	// ********************************************************
	always_comb begin
		r_d       = r_q;
		r_d.rdata = '0;
		if (irq_rd) begin
			r_d.irq = '0;
		end
		if (ack_wr) begin
			r_d.lock = 1'b0;
		end

		unique case (r_q.st)
			BFM_ST_STANDBY: begin
				if (trig) begin
					r_d.st                 = BFM_ST_RUN;
					r_d.irq[`BFM_IRQ_START] = 1'b1;
				end
			end
			BFM_ST_RUN: begin
				// opening found in the expiry cycle still counts as in time
				if (opened) begin
					if (trig) begin
						r_d.st               = BFM_ST_REJECT;
						r_d.irq[`BFM_IRQ_REJ] = 1'b1;
					end else begin
						r_d.st = BFM_ST_STANDBY;
					end
				end else if (tmr_exp) begin
					r_d.st                 = BFM_ST_TRIP;
					r_d.lock               = 1'b1;
					r_d.irq[`BFM_IRQ_FAIL] = 1'b1;
				end
			end
			BFM_ST_REJECT: begin
				if (!trig) begin
					r_d.st = BFM_ST_STANDBY;
				end
			end
			BFM_ST_TRIP: begin
				if (!trig) begin
					r_d.st = BFM_ST_STANDBY;
				end
			end
		endcase

		if (wr_i) begin
			unique case (addr_i)
				`BFM_CTRL_OFS: begin
					r_d.sch  = wdata_i[`BFM_CTRL_SCH_LSB +: 2];
					r_d.tsel = wdata_i[`BFM_CTRL_TSEL_LSB +: 2];
					r_d.xen  = wdata_i[`BFM_CTRL_XEN_LSB +: NX];
				end
				// too short a time trips healthy breakers
				`BFM_SUPV_OFS: r_d.supv = wdata_i[TW-1:0];
				`BFM_THR_OFS:  r_d.thr  = wdata_i[CW-1:0];
				`BFM_MASK_OFS: r_d.mask = wdata_i[2:0];
				default: ;
			endcase
		end

		if (rd_i) begin
			unique case (addr_i)
				`BFM_CTRL_OFS: begin
					r_d.rdata[`BFM_CTRL_SCH_LSB +: 2]   = r_q.sch;
					r_d.rdata[`BFM_CTRL_TSEL_LSB +: 2]  = r_q.tsel;
					r_d.rdata[`BFM_CTRL_XEN_LSB +: NX]  = r_q.xen;
				end
				`BFM_SUPV_OFS: r_d.rdata[TW-1:0] = r_q.supv;
				`BFM_THR_OFS:  r_d.rdata[CW-1:0] = r_q.thr;
				`BFM_STAT_OFS: r_d.rdata[5:0]    = {trig, opened, r_q.lock,
					r_q.st == BFM_ST_TRIP, r_q.st};
				`BFM_IRQ_OFS:  r_d.rdata[2:0]    = r_q.irq;
				`BFM_MASK_OFS: r_d.rdata[2:0]    = r_q.mask;
				`BFM_TMR_OFS:  r_d.rdata[TW-1:0] = tmr_cnt;
				default: ;
			endcase
		end
	end

	// lock survives only through reset-free operation; no non-volatile copy here
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			r_q      <= '0;
			r_q.st   <= BFM_ST_STANDBY;
			r_q.thr  <= CW'(`BFM_THR_RST);
			r_q.supv <= TW'(`BFM_SUPV_CYC);
			r_q.mask <= `BFM_MASK_RST;
		end else begin
			r_q <= r_d;
		end
	end

	// ********************************************************
	// outputs
	// ********************************************************
	assign backup_trip_o = (r_q.st == BFM_ST_TRIP);
	assign lock_o        = r_q.lock;
	assign irq_o         = |(r_q.irq & r_q.mask);
	assign rdata_o       = r_q.rdata;

	// ********************************************************
	// assertions
	// ********************************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	property p_cur_stop;
		(r_q.st == BFM_ST_RUN) && (r_q.sch == BFM_SCH_CURRENT) && cur_below |=> r_q.st != BFM_ST_TRIP;
	endproperty
	a_cur_stop: assert property (p_cur_stop) else $error("current drop did not prevent trip");

	property p_cur_fail;
		(r_q.st == BFM_ST_RUN) && (r_q.sch == BFM_SCH_CURRENT) && tmr_exp && !cur_below
			|=> backup_trip_o;
	endproperty
	a_cur_fail: assert property (p_cur_fail) else $error("current check missed failure");

	property p_pos_stop;
		(r_q.st == BFM_ST_RUN) && (r_q.sch == BFM_SCH_POSITION) && pos_open_s |=> r_q.st != BFM_ST_TRIP;
	endproperty
	a_pos_stop: assert property (p_pos_stop) else $error("position open did not prevent trip");

	property p_comb_both;
		(r_q.st == BFM_ST_RUN) && (r_q.sch == BFM_SCH_COMBINED) && tmr_exp && (cur_below != pos_open_s)
			|=> backup_trip_o;
	endproperty
	a_comb_both: assert property (p_comb_both) else $error("combined scheme took one indication");

	property p_start;
		start |=> (r_q.st == BFM_ST_RUN) && (tmr_cnt == $past(r_q.supv));
	endproperty
	a_start: assert property (p_start) else $error("timer not loaded on trigger");

	property p_keep_run;
		(r_q.st == BFM_ST_RUN) && !opened && !tmr_exp && !trig |=> r_q.st == BFM_ST_RUN;
	endproperty
	a_keep_run: assert property (p_keep_run) else $error("timer dropped with trigger");

	property p_trip_lock;
		$rose(backup_trip_o) |-> lock_o && $past(tmr_exp) && !$past(opened);
	endproperty
	a_trip_lock: assert property (p_trip_lock) else $error("trip without expiry or lock");

	property p_lock_cause;
		$rose(lock_o) |-> $rose(backup_trip_o);
	endproperty
	a_lock_cause: assert property (p_lock_cause) else $error("lock rose apart from trip");

	property p_open_stop;
		(r_q.st == BFM_ST_RUN) && opened |=> r_q.st inside {BFM_ST_STANDBY, BFM_ST_REJECT} ##1 !backup_trip_o;
	endproperty
	a_open_stop: assert property (p_open_stop) else $error("opening did not stop timer");

	property p_reject;
		(r_q.st == BFM_ST_RUN) && opened && trig |=> r_q.st == BFM_ST_REJECT;
	endproperty
	a_reject: assert property (p_reject) else $error("opening under trigger not rejected");

	property p_reject_hold;
		(r_q.st == BFM_ST_REJECT) && trig |=> r_q.st == BFM_ST_REJECT;
	endproperty
	a_reject_hold: assert property (p_reject_hold) else $error("left rejected with trigger");

	property p_back;
		(r_q.st inside {BFM_ST_REJECT, BFM_ST_TRIP}) && !trig |=> r_q.st == BFM_ST_STANDBY;
	endproperty
	a_back: assert property (p_back) else $error("no return to standby");

	property p_lock_hold;
		lock_o && !ack_wr |=> lock_o;
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("lock cleared without acknowledge");

	property p_sel_none;
		(r_q.tsel == BFM_TS_NONE) && (r_q.xen == '0) |-> !trig;
	endproperty
	a_sel_none: assert property (p_sel_none) else $error("trigger with no source");

	property p_tsel_ext;
		(r_q.tsel == BFM_TS_EXT) && (r_q.xen == '0) |-> trig == trip_ext_i;
	endproperty
	a_tsel_ext: assert property (p_tsel_ext) else $error("external selection took another source");

	// expiry with no opening is the one path to the backup trip
	property p_expiry_trip;
		(r_q.st == BFM_ST_RUN) && tmr_exp && !opened |=> backup_trip_o && lock_o;
	endproperty
	a_expiry_trip: assert property (p_expiry_trip) else $error("expiry did not trip");

	property p_pos_fail;
		(r_q.st == BFM_ST_RUN) && (r_q.sch == BFM_SCH_POSITION) && tmr_exp && !pos_open_s |=> backup_trip_o;
	endproperty
	a_pos_fail: assert property (p_pos_fail) else $error("position check missed failure");

	// a stalled count would never reach expiry and hide a stuck breaker
	property p_timer_run;
		(r_q.st == BFM_ST_RUN) && !opened && !tmr_exp |=> tmr_cnt == $past(tmr_cnt) - 1'b1;
	endproperty
	a_timer_run: assert property (p_timer_run) else $error("supervision count did not advance");

	property p_trip_stand;
		backup_trip_o && trig |=> backup_trip_o;
	endproperty
	a_trip_stand: assert property (p_trip_stand) else $error("backup trip dropped under trigger");

	// a new failure in the acknowledge cycle keeps the lock, so it is left out here
	property p_lock_ack;
		lock_o && ack_wr && !((r_q.st == BFM_ST_RUN) && tmr_exp && !opened) |=> !lock_o;
	endproperty
	a_lock_ack: assert property (p_lock_ack) else $error("acknowledge did not clear lock");

	property p_rdata_idle;
		!rd_i |=> rdata_o == '0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read strobe");

	property p_reset;
		@(posedge clk_i) disable iff (1'b0) srst_i |=> (r_q.st == BFM_ST_STANDBY) && !backup_trip_o && !lock_o;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");

	c_trip:   cover property ($rose(backup_trip_o));
	c_reject: cover property ((r_q.st == BFM_ST_RUN) ##1 (r_q.st == BFM_ST_REJECT));
	c_ack:    cover property (lock_o && ack_wr ##1 !lock_o);
	c_comb:   cover property ((r_q.sch == BFM_SCH_COMBINED) && $rose(backup_trip_o));
	c_sch3:   cover property ((r_q.sch == 2'b11) && $rose(backup_trip_o));
endmodule

/* src/bfm_map.svh */
// register offsets, field positions, reset values and timing counts of the breaker failure monitor
// assumes a 250 MHz system clock and a plain one-cycle register port
`ifndef BFM_MAP_SVH
`define BFM_MAP_SVH

`define BFM_AW           8
`define BFM_DW           32

`define BFM_CTRL_OFS     8'h00
`define BFM_SUPV_OFS     8'h04
`define BFM_THR_OFS      8'h08
`define BFM_STAT_OFS     8'h0c
`define BFM_IRQ_OFS      8'h10
`define BFM_MASK_OFS     8'h14
`define BFM_ACK_OFS      8'h18
`define BFM_TMR_OFS      8'h1c

`define BFM_CTRL_SCH_LSB 0
`define BFM_CTRL_TSEL_LSB 2
`define BFM_CTRL_XEN_LSB 4

`define BFM_IRQ_FAIL     0
`define BFM_IRQ_REJ      1
`define BFM_IRQ_START    2

`define BFM_THR_RST      16'h0100
`define BFM_MASK_RST     3'h0

`define BFM_CLK_NS       4
`define BFM_SUPV_NS      2000
`define BFM_SUPV_CYC     ((`BFM_SUPV_NS + `BFM_CLK_NS - 1) / `BFM_CLK_NS)

`endif

/* src/bfm_pkg.sv */
// types of the breaker failure monitor
// constants live in bfm_map.svh
package bfm_pkg;

	typedef enum logic [1:0] {
		BFM_ST_STANDBY = 2'b00,
		BFM_ST_RUN     = 2'b01,
		BFM_ST_REJECT  = 2'b10,
		BFM_ST_TRIP    = 2'b11
	} bfm_state_t;

	typedef enum logic [1:0] {
		BFM_SCH_CURRENT  = 2'b00,
		BFM_SCH_POSITION = 2'b01,
		BFM_SCH_COMBINED = 2'b10
	} bfm_scheme_t;

	typedef enum logic [1:0] {
		BFM_TS_ALL     = 2'b00,
		BFM_TS_EXT     = 2'b01,
		BFM_TS_CURRENT = 2'b10,
		BFM_TS_NONE    = 2'b11
	} bfm_tsel_t;

endpackage

/* src/bfm_sync.sv */
// two-flop synchroniser for pin levels
// assumes inputs are slow levels, not pulses
`timescale 1ns/1ps
module bfm_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         srst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} bfm_sync_t;

	bfm_sync_t r_q;
	bfm_sync_t r_d;

	always_comb begin
		r_d    = r_q;
		r_d.s1 = d_i;
		r_d.s2 = r_q.s1;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign q_o = r_q.s2;
endmodule

/* src/bfm_timer.sv */
// supervision down-counter with load, stop and expiry flag
// assumes load and stop never needed in one cycle; load wins
`timescale 1ns/1ps
module bfm_timer #(
	parameter int TW = 32
) (
	input  wire logic          clk_i,
	input  wire logic          srst_i,
	input  wire logic          load_i,
	input  wire logic          stop_i,
	input  wire logic [TW-1:0] load_val_i,
	output logic      [TW-1:0] cnt_o,
	output logic               exp_o
);
	typedef struct packed {
		logic          armed;
		logic [TW-1:0] cnt;
	} bfm_tmr_t;

	bfm_tmr_t r_q;
	bfm_tmr_t r_d;

	always_comb begin
		r_d = r_q;
		if (load_i) begin
			r_d.armed = 1'b1;
			r_d.cnt   = load_val_i;
		end else if (stop_i) begin
			r_d.armed = 1'b0;
		end else if (r_q.armed && (r_q.cnt != '0)) begin
			r_d.cnt = r_q.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign cnt_o = r_q.cnt;
	assign exp_o = r_q.armed && (r_q.cnt == '0);
endmodule

/* tb/bfm_breaker_model.sv */
// breaker model: load current and open-position pin of the supervised breaker
// assumes cmd_i is the trip command level that the breaker coil sees
`timescale 1ns/1ps
module bfm_breaker_model (
	input  wire logic        clk_i,
	input  wire logic        cmd_i,
	input  wire logic [3:0]  dly_i,
	input  wire logic [15:0] load_i,
	input  wire logic        stuck_cur_i,
	input  wire logic        stuck_pos_i,
	output logic      [15:0] current_o,
	output logic             pos_open_o
);
	// ****************
	// opening
	// ****************
	logic [3:0] cnt_q;
	logic       open_q;
	always_ff @(posedge clk_i) begin
		if (!cmd_i) begin
			cnt_q  <= 4'h0;
			open_q <= 1'h0;
		end else if (cnt_q == dly_i) begin
			open_q <= 1'h1;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
	// a stuck pole keeps full load and a stuck contact keeps showing closed
	assign current_o  = (open_q && !stuck_cur_i) ? {8'h00, load_i[7:0]} : {1'h1, load_i[14:0]};
	assign pos_open_o = open_q && !stuck_pos_i;
endmodule

/* tb/bfm_top_bench.sv */
// self-checking bench of the breaker failure monitor with a breaker model
// assumes bfm_pkg, bfm_top and bfm_map.svh are compiled before it
`timescale 1ns/1ps
`include "bfm_map.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("ERROR %0t: got %h exp %h", $time, (g), (e)); end end
module bfm_top_bench
	import bfm_pkg::*;
();
	logic        clk_i, srst_i, wr_i, rd_i, trip_ext_i, trip_cur_i, trip_other_i;
	logic        pos_open_i, backup_trip_o, lock_o, irq_o, stuck_c, stuck_p, fl;
	logic [7:0]  addr_i;
	logic [31:0] wdata_i, rdata_o, rv;
	logic [2:0]  extra_trigger_i;
	logic [15:0] current_i, load;
	logic [3:0]  dly;
	int          n_fail, n_tests, v, n, s, tsel, sch, k;

	bfm_top i_bfm_top (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .trip_ext_i(trip_ext_i), .trip_cur_i(trip_cur_i),
		.trip_other_i(trip_other_i), .extra_trigger_i(extra_trigger_i), .current_i(current_i),
		.pos_open_i(pos_open_i), .backup_trip_o(backup_trip_o), .lock_o(lock_o), .irq_o(irq_o));
	bfm_breaker_model i_bfm_breaker_model (.clk_i(clk_i),
		.cmd_i(trip_ext_i | trip_cur_i | trip_other_i | (|extra_trigger_i)), .dly_i(dly), .load_i(load),
		.stuck_cur_i(stuck_c), .stuck_pos_i(stuck_p), .current_o(current_i), .pos_open_o(pos_open_i));

	initial begin
		clk_i = 1'h0;
		forever #2 clk_i = ~clk_i;
	end

	// ****************
	// bus and stimulus tasks
	// ****************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'h1;
		@(posedge clk_i);
		wr_i <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'h1;
		@(posedge clk_i);
		rd_i <= 1'h0;
		#1;
		rv = rdata_o;
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		`CHK(rv, e)
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge clk_i);
		#1;
	endtask
	task automatic trig(input int src, input logic lv);
		@(posedge clk_i);
		case (src)
			0: trip_ext_i <= lv;
			1: trip_cur_i <= lv;
			2: trip_other_i <= lv;
			default: extra_trigger_i <= {2'h0, lv};
		endcase
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ****************
	// expectations
	// ****************
	function automatic logic exp_start(input int ts, input int src);
		return src == 3 || (ts == 0 && src < 3) || (ts == 1 && src == 0) || (ts == 2 && src == 1);
	endfunction
	function automatic logic exp_fail(input int sc, input logic c, input logic p);
		return (sc == 0) ? c : (sc == 1) ? p : (c | p);
	endfunction

	// ****************
	// main sequence
	// ****************
	initial begin
		{wr_i, rd_i, trip_ext_i, trip_cur_i, trip_other_i, stuck_c, stuck_p} = 7'h00;
		addr_i          = 8'h00;
		wdata_i         = 32'h0;
		extra_trigger_i = 3'h0;
		load            = 16'h8000;
		dly             = 4'h2;
		srst_i          = 1'h1;
		n_fail          = 0;
		n_tests         = 0;
		rv              = $urandom(72);
		repeat (6) @(posedge clk_i);
		srst_i <= 1'h0;
		cyc(1);
		`CHK({backup_trip_o, lock_o, irq_o}, 3'h0)
		chk_rd(`BFM_CTRL_OFS, 32'h0);
		chk_rd(`BFM_SUPV_OFS, 32'h1f4);
		chk_rd(`BFM_THR_OFS, 32'h100);
		chk_rd(`BFM_STAT_OFS, 32'h0);
		chk_rd(`BFM_IRQ_OFS, 32'h0);
		wr(8'h20, 32'hffffffff);
		chk_rd(8'h20, 32'h0);
		wr(`BFM_MASK_OFS, 32'h1);
		chk_rd(`BFM_MASK_OFS, 32'h1);
		// every selection against the three trip inputs and extra trigger bit 0; the breaker opens so each start ends rejected
		for (tsel = 0; tsel < 4; tsel++) begin
			for (s = 0; s < 4; s++) begin
				wr(`BFM_CTRL_OFS, {25'h0, 2'h0, (s == 3), tsel[1:0], 2'h0});
				wr(`BFM_SUPV_OFS, 32'h0c);
				trig(s, 1'h1);
				cyc(14);
				trig(s, 1'h0);
				cyc(3);
				chk_rd(`BFM_IRQ_OFS, exp_start(tsel, s) ? 32'h6 : 32'h0);
			end
		end
		// every scheme against a healthy, current-stuck, position-stuck and fully stuck breaker
		for (sch = 0; sch < 4; sch++) begin
			for (k = 0; k < 4; k++) begin
				v       = 8 + $urandom_range(12, 0);
				dly     = 4'($urandom_range(3, 1));
				load    = 16'($urandom());
				stuck_c = k[0];
				stuck_p = k[1];
				s       = $urandom_range(2, 0);
				fl      = exp_fail(sch, k[0], k[1]);
				wr(`BFM_CTRL_OFS, {30'h0, sch[1:0]});
				wr(`BFM_SUPV_OFS, 32'(v));
				trig(s, 1'h1);
				if (fl) begin
					for (n = 1; n <= 40; n++) begin
						@(posedge clk_i);
						#1;
						if (backup_trip_o === 1'h1) break;
					end
					if (n > 40) begin
						n_fail++;
						$display("ERROR %0t: backup trip never came", $time);
						stop_test();
					end
					`CHK(n, v + 2)
					`CHK(lock_o, 1'h1)
					chk_rd(`BFM_TMR_OFS, 32'h0);
				end else begin
					cyc(v + 4);
					`CHK(backup_trip_o, 1'h0)
					rd(`BFM_STAT_OFS);
					`CHK(rv[5:0], 6'h32)
				end
				trig(s, 1'h0);
				cyc(2);
				if (fl) begin
					`CHK({backup_trip_o, lock_o, irq_o}, 3'h3)
					chk_rd(`BFM_IRQ_OFS, 32'h5);
					`CHK(irq_o, 1'h0)
					wr(`BFM_ACK_OFS, 32'h2);
					#1;
					`CHK(lock_o, 1'h1)
					wr(`BFM_ACK_OFS, 32'h1);
					#1;
					`CHK(lock_o, 1'h0)
				end else begin
					rd(`BFM_STAT_OFS);
					`CHK(rv[1:0], 2'h0)
					chk_rd(`BFM_IRQ_OFS, 32'h6);
				end
			end
		end
		// a one-cycle trigger must still run the timer to a trip
		stuck_c = 1'h1;
		wr(`BFM_CTRL_OFS, 32'h0);
		trig(0, 1'h1);
		trig(0, 1'h0);
		cyc(v + 4);
		`CHK(lock_o, 1'h1)
		chk_rd(`BFM_IRQ_OFS, 32'h5);
		// a reset after the trip, back in standby, must drop the latched lock and restore the defaults
		@(posedge clk_i);
		srst_i <= 1'h1;
		repeat (2) @(posedge clk_i);
		srst_i <= 1'h0;
		cyc(1);
		`CHK({backup_trip_o, lock_o, irq_o}, 3'h0)
		chk_rd(`BFM_SUPV_OFS, 32'h1f4);
		chk_rd(`BFM_STAT_OFS, 32'h0);
		stop_test();
	end
endmodule
